/* src/tvio_ports.v */
// Three general-purpose ports with serial overlay and edge interrupts
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tvio_defines.vh"
// What this block does
// (RULE1) First port: eight lines, direction and pull-up
// (RULE2) First port lines four-seven drive open-drain
// (RULE3) First port lines four-seven ignore pull-up
// (RULE4) First port lines zero-three drive push-pull
// (RULE5) Second port: six lines, no lines three and seven
// (RULE6) Third port: eight lines, direction and pull-up
// (RULE7) Third port open-drain; upper four lack pull-up
// (RULE8) Serial lines: pin is data AND serial
// (RULE9) Clock line0, data line1, enable line3
// (RULE10) Lines four, six: software-edge interrupt latches
// (RULE11) Line four power, line six infrared
// (RULE12) Direction bit per line; reads return pins
module tvio_ports (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Register port
  input wire [`TVIO_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Serial interface overlay
  input wire serial_clock_i,
  input wire serial_data_i,
  input wire serial_bus_enable_i,
  // First port pins
  input wire [7:0] first_port_lines_i,
  output reg [7:0] first_port_lines_o,
  output reg [7:0] first_port_lines_oe_o,
  output reg [7:0] first_port_lines_pu_o,
  // Second port pins
  input wire [7:0] second_port_lines_i,
  output reg [7:0] second_port_lines_o,
  output reg [7:0] second_port_lines_oe_o,
  output reg [7:0] second_port_lines_pu_o,
  // Third port pins
  input wire [7:0] third_port_lines_i,
  output reg [7:0] third_port_lines_o,
  output reg [7:0] third_port_lines_oe_o,
  output reg [7:0] third_port_lines_pu_o,
  // Interrupts
  output reg power_interrupt_input_o,
  output reg infrared_nonmaskable_interrupt_o,
  output reg irq_o
);
  // ************
  // Registers
  // ************
  reg [7:0] a_data;
  reg [7:0] a_dir;
  reg [7:0] a_pull;
  reg [7:0] b_data;
  reg [7:0] b_dir;
  reg [7:0] b_pull;
  reg [7:0] c_data;
  reg [7:0] c_dir;
  reg [7:0] c_pull;
  reg [1:0] edge_sel;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [1:0] ev_last;
  wire [7:0] a_pin;
  wire [7:0] b_pin;
  wire [7:0] c_pin;
  wire [7:0] ser_vec;
  wire [7:0] c_drive;
  wire [1:0] ev_now;
  wire [1:0] ev_hit;
  reg [7:0] next_rdata;

  // ************
  // Pin synchronisers
  // ************
  tvio_sync #(.W(8)) u_sync_a (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(first_port_lines_i),
    .q_o(a_pin)
  );
  tvio_sync #(.W(8)) u_sync_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(second_port_lines_i),
    .q_o(b_pin)
  );
  tvio_sync #(.W(8)) u_sync_c (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(third_port_lines_i),
    .q_o(c_pin)
  );

  // ************
  // Register writes
  // ************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_data <= `TVIO_RST_ZERO;
      a_dir <= `TVIO_RST_ZERO;
      a_pull <= `TVIO_RST_ZERO;
      b_data <= `TVIO_RST_ZERO;
      b_dir <= `TVIO_RST_ZERO;
      b_pull <= `TVIO_RST_ZERO;
      c_data <= `TVIO_RST_ZERO;
      c_dir <= `TVIO_RST_ZERO;
      c_pull <= `TVIO_RST_ZERO;
      edge_sel <= 2'h0;
      irq_mask <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `TVIO_OFF_A_DATA: a_data <= wdata_i;
        `TVIO_OFF_A_DIR: a_dir <= wdata_i; // RULE1
        `TVIO_OFF_A_PULL: a_pull <= wdata_i & `TVIO_A_PULL_OK; // RULE3
        `TVIO_OFF_B_DATA: b_data <= wdata_i & `TVIO_B_LINES; // RULE5
        `TVIO_OFF_B_DIR: b_dir <= wdata_i & `TVIO_B_LINES; // RULE5
        `TVIO_OFF_B_PULL: b_pull <= wdata_i & `TVIO_B_LINES; // RULE5
        `TVIO_OFF_C_DATA: c_data <= wdata_i;
        `TVIO_OFF_C_DIR: c_dir <= wdata_i; // RULE6
        `TVIO_OFF_C_PULL: c_pull <= wdata_i & `TVIO_C_PULL_OK; // RULE7
        `TVIO_OFF_EDGE: edge_sel <= wdata_i[1:0]; // RULE10
        `TVIO_OFF_IRQ_MASK: irq_mask <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ************
  // Edge latches
  // ************
  // Edge select bit one means rising edge, zero means falling
  assign ev_now = {c_pin[`TVIO_BIT_IR], c_pin[`TVIO_BIT_PWR]}; // RULE11
  assign ev_hit = (ev_now & ~ev_last & edge_sel) |
                  (~ev_now & ev_last & ~edge_sel); // RULE10

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_last <= 2'h0;
      irq_stat <= 2'h0;
    end else begin
      ev_last <= ev_now;
      // Set wins over a write-one clear in the same cycle
      if (wr_i && addr_i == `TVIO_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wdata_i[1:0]) | ev_hit; // RULE10
      end else begin
        irq_stat <= irq_stat | ev_hit; // RULE10
      end
    end
  end

  // ************
  // Pin drive
  // ************
  // Serial signals idle high so the port value passes through
  assign ser_vec = {4'hF, serial_bus_enable_i, 1'b1, serial_data_i, serial_clock_i}; // RULE9
  assign c_drive = c_data & (ser_vec | ~`TVIO_C_SER_LINES); // RULE8

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_port_lines_o <= `TVIO_RST_ZERO;
      first_port_lines_oe_o <= `TVIO_RST_ZERO;
      first_port_lines_pu_o <= `TVIO_RST_ZERO;
      second_port_lines_o <= `TVIO_RST_ZERO;
      second_port_lines_oe_o <= `TVIO_RST_ZERO;
      second_port_lines_pu_o <= `TVIO_RST_ZERO;
      third_port_lines_o <= `TVIO_RST_ZERO;
      third_port_lines_oe_o <= `TVIO_RST_ZERO;
      third_port_lines_pu_o <= `TVIO_RST_ZERO;
      power_interrupt_input_o <= 1'b0;
      infrared_nonmaskable_interrupt_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      first_port_lines_o <= a_data & ~`TVIO_A_OD; // RULE4
      // Open-drain lines only ever pull low
      first_port_lines_oe_o <= a_dir & (~`TVIO_A_OD | ~a_data); // RULE2
      first_port_lines_pu_o <= ~a_dir & a_pull; // RULE12
      second_port_lines_o <= b_data; // RULE5
      second_port_lines_oe_o <= b_dir; // RULE5
      second_port_lines_pu_o <= ~b_dir & b_pull; // RULE12
      third_port_lines_o <= `TVIO_RST_ZERO; // RULE7
      third_port_lines_oe_o <= c_dir & ~c_drive; // RULE7
      third_port_lines_pu_o <= ~c_dir & c_pull; // RULE12
      power_interrupt_input_o <= irq_stat[`TVIO_EV_PWR]; // RULE11
      infrared_nonmaskable_interrupt_o <= irq_stat[`TVIO_EV_IR]; // RULE11
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ************
  // Register reads
  // ************
  always @* begin
    next_rdata = 8'h00;
    case (addr_i)
      `TVIO_OFF_A_DATA: next_rdata = a_data;
      `TVIO_OFF_A_DIR: next_rdata = a_dir;
      `TVIO_OFF_A_PULL: next_rdata = a_pull;
      `TVIO_OFF_A_PIN: next_rdata = a_pin; // RULE12
      `TVIO_OFF_B_DATA: next_rdata = b_data;
      `TVIO_OFF_B_DIR: next_rdata = b_dir;
      `TVIO_OFF_B_PULL: next_rdata = b_pull;
      `TVIO_OFF_B_PIN: next_rdata = b_pin & `TVIO_B_LINES; // RULE12
      `TVIO_OFF_C_DATA: next_rdata = c_data;
      `TVIO_OFF_C_DIR: next_rdata = c_dir;
      `TVIO_OFF_C_PULL: next_rdata = c_pull;
      `TVIO_OFF_C_PIN: next_rdata = c_pin; // RULE12
      `TVIO_OFF_EDGE: next_rdata = {6'h00, edge_sel};
      `TVIO_OFF_IRQ_STAT: next_rdata = {6'h00, irq_stat};
      `TVIO_OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // tvio_ports
`default_nettype wire

/* src/tvio_defines.vh */
// Constants for the TV controller general-purpose port block
`ifndef TVIO_DEFINES_VH
`define TVIO_DEFINES_VH
// ************
// Register offsets
// ************
`define TVIO_ADDR_W 5
`define TVIO_OFF_A_DATA 5'h00
`define TVIO_OFF_A_DIR 5'h01
`define TVIO_OFF_A_PULL 5'h02
`define TVIO_OFF_A_PIN 5'h03
`define TVIO_OFF_B_DATA 5'h04
`define TVIO_OFF_B_DIR 5'h05
`define TVIO_OFF_B_PULL 5'h06
`define TVIO_OFF_B_PIN 5'h07
`define TVIO_OFF_C_DATA 5'h08
`define TVIO_OFF_C_DIR 5'h09
`define TVIO_OFF_C_PULL 5'h0A
`define TVIO_OFF_C_PIN 5'h0B
`define TVIO_OFF_EDGE 5'h0C
`define TVIO_OFF_IRQ_STAT 5'h0D
`define TVIO_OFF_IRQ_MASK 5'h0E
// ************
// Line masks and reset values
// ************
`define TVIO_A_PULL_OK 8'h0F
`define TVIO_A_OD 8'hF0
`define TVIO_B_LINES 8'h77
`define TVIO_C_PULL_OK 8'h0F
`define TVIO_C_SER_LINES 8'h0B
`define TVIO_RST_ZERO 8'h00
// ************
// Field positions
// ************
`define TVIO_BIT_SCL 0
`define TVIO_BIT_SDA 1
`define TVIO_BIT_SEN 3
`define TVIO_BIT_PWR 4
`define TVIO_BIT_IR 6
`define TVIO_EV_PWR 0
`define TVIO_EV_IR 1
`endif

/* src/tvio_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tvio_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Pin in, filtered level out
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar g;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A change counts only once stages two and three agree
  generate
    for (g = 0; g < W; g = g + 1) begin : g_filt
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          q_o[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          q_o[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule // tvio_sync
`default_nettype wire

/* tb/tvio_board.sv */
// Board-side pin model: drivers, pull-ups and outside levels
`timescale 1ns/100ps
`default_nettype none
module tvio_board (
  // Block side
  input wire logic [7:0] o_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pu_i,
  // Board side
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  // Driver wins, then pull-up, then the board level
  assign pin_o = (oe_i & o_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ext_i);
endmodule // tvio_board
`default_nettype wire

/* tb/tvio_ports_properties.sv */
// Assertion checker for the port block
`timescale 1ns/100ps
`default_nettype none
`include "tvio_defines.vh"
module tvio_ports_properties (
  // Clock, reset, register port
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [`TVIO_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pin controls
  input wire logic [7:0] first_port_lines_o,
  input wire logic [7:0] first_port_lines_oe_o,
  input wire logic [7:0] first_port_lines_pu_o,
  input wire logic [7:0] second_port_lines_oe_o,
  input wire logic [7:0] second_port_lines_pu_o,
  input wire logic [7:0] third_port_lines_o,
  input wire logic [7:0] third_port_lines_pu_o,
  // Interrupt
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  od_upper_a: assert property (first_port_lines_o[7:4] == 4'h0)
    else $error("upper first lines drive high");
  a_nopull_a: assert property (first_port_lines_pu_o[7:4] == 4'h0)
    else $error("upper first lines pulled up");
  // Register lands on the write edge, pin outputs one edge later
  pp_data_a: assert property (wr_i && addr_i == `TVIO_OFF_A_DATA
    |=> ##1 ($past(wdata_i, 2) & 8'h0F) == {4'h0, first_port_lines_o[3:0]})
    else $error("push-pull value wrong");
  dir_low_a: assert property (wr_i && addr_i == `TVIO_OFF_A_DIR
    |=> ##1 ($past(wdata_i, 2) & 8'h0F) == {4'h0, first_port_lines_oe_o[3:0]})
    else $error("direction not applied");
  b_hole_a: assert property (((second_port_lines_oe_o | second_port_lines_pu_o)
    & 8'h88) == 8'h00) else $error("missing second line active");
  c_od_a: assert property (third_port_lines_o == 8'h00
    && third_port_lines_pu_o[7:4] == 4'h0) else $error("third port drive wrong");
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  irq_mask_a: assert property (wr_i && addr_i == `TVIO_OFF_IRQ_MASK
    && wdata_i == 8'h00 |=> ##2 !irq_o) else $error("masked interrupt high");
  cover property (wr_i && addr_i == `TVIO_OFF_A_DATA);
  cover property (irq_o);
  cover property (rd_i ##1 rdata_o != 8'h00);
endmodule // tvio_ports_properties
bind tvio_ports tvio_ports_properties i_chk (.clk_i, .rstn_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .first_port_lines_o, .first_port_lines_oe_o,
  .first_port_lines_pu_o, .second_port_lines_oe_o, .second_port_lines_pu_o,
  .third_port_lines_o, .third_port_lines_pu_o, .irq_o);
`default_nettype wire

/* tb/tvio_ports_tb_top.sv */
// Self-checking bench for the port block
`timescale 1ns/100ps
`default_nettype none
`include "tvio_defines.vh"
module tvio_ports_tb_top;
  logic clk_i, rstn_i, wr_i, rd_i;
  logic [4:0] addr_i;
  logic [7:0] wdata_i, ext_a, ext_b, ext_c;
  logic [2:0] ser;
  wire [7:0] rdata_o, pin_a, pin_b, pin_c, ao, aoe, apu, bo, boe, bpu, co, coe, cpu;
  wire pwr, ir, irq;
  int miscompares = 0;
  int num_checks = 0;
  tvio_ports i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .serial_clock_i(ser[0]), .serial_data_i(ser[1]), .serial_bus_enable_i(ser[2]),
    .first_port_lines_i(pin_a), .first_port_lines_o(ao),
    .first_port_lines_oe_o(aoe), .first_port_lines_pu_o(apu),
    .second_port_lines_i(pin_b), .second_port_lines_o(bo),
    .second_port_lines_oe_o(boe), .second_port_lines_pu_o(bpu),
    .third_port_lines_i(pin_c), .third_port_lines_o(co),
    .third_port_lines_oe_o(coe), .third_port_lines_pu_o(cpu),
    .power_interrupt_input_o(pwr), .infrared_nonmaskable_interrupt_o(ir), .irq_o(irq));
  tvio_board i_ma (.o_i(ao), .oe_i(aoe), .pu_i(apu), .ext_i(ext_a), .pin_o(pin_a));
  tvio_board i_mb (.o_i(bo), .oe_i(boe), .pu_i(bpu), .ext_i(ext_b), .pin_o(pin_b));
  tvio_board i_mc (.o_i(co), .oe_i(coe), .pu_i(cpu), .ext_i(ext_c), .pin_o(pin_c));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  task automatic t_irq;
    wr(`TVIO_OFF_EDGE, 8'h03);
    wr(`TVIO_OFF_IRQ_MASK, 8'h01);
    ext_c <= 8'h50;
    repeat (8) @(posedge clk_i);
    #1 chk("pwr", 8'h01, {7'h0, pwr});
    chk("ir", 8'h01, {7'h0, ir});
    chk("irq", 8'h01, {7'h0, irq});
    rd(`TVIO_OFF_IRQ_STAT, 8'h03, "stat");
    wr(`TVIO_OFF_IRQ_MASK, 8'h00);
    wr(`TVIO_OFF_IRQ_STAT, 8'h03);
    wr(`TVIO_OFF_EDGE, 8'h00);
    ext_c <= 8'h10;
    repeat (8) @(posedge clk_i);
    #1 chk("irq", 8'h00, {7'h0, irq});
    rd(`TVIO_OFF_IRQ_STAT, 8'h02, "stat");
    $display("irq test done");
  endtask
  task automatic t_a;
    wr(`TVIO_OFF_A_DIR, 8'hFF);
    wr(`TVIO_OFF_A_DATA, 8'h5A);
    repeat (6) @(posedge clk_i);
    #1 chk("pin_a", 8'h0A, pin_a);
    rd(`TVIO_OFF_A_PIN, 8'h0A, "a_pin");
    wr(`TVIO_OFF_A_DIR, 8'h00);
    wr(`TVIO_OFF_A_PULL, 8'hFF);
    repeat (2) @(posedge clk_i);
    #1 chk("pin_a", 8'h0F, pin_a);
    rd(`TVIO_OFF_A_PULL, 8'h0F, "a_pull");
    $display("first port test done");
  endtask
  task automatic t_bc;
    ext_c <= 8'h00;
    wr(`TVIO_OFF_B_PULL, 8'hFF);
    wr(`TVIO_OFF_C_PULL, 8'hFF);
    repeat (2) @(posedge clk_i);
    #1 chk("pin_b", 8'h77, pin_b);
    chk("pin_c", 8'h0F, pin_c);
    rd(`TVIO_OFF_B_PULL, 8'h77, "b_pull");
    rd(5'h1F, 8'h00, "unmapped");
    wr(`TVIO_OFF_B_DIR, 8'hFF);
    wr(`TVIO_OFF_B_DATA, 8'h55);
    repeat (6) @(posedge clk_i);
    #1 chk("pin_b_out", 8'h55, pin_b);
    rd(`TVIO_OFF_B_PIN, 8'h55, "b_pin");
    $display("pull-up test done");
  endtask
  task automatic t_serial;
    wr(`TVIO_OFF_C_PULL, 8'h00);
    wr(`TVIO_OFF_C_DIR, 8'hFF);
    wr(`TVIO_OFF_C_DATA, 8'hFF);
    ext_c <= 8'hFF;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      ser <= ~(3'b001 << k);
      repeat (3) @(posedge clk_i);
      #1 chk("pin_c", ~(8'h01 << ((k == 2) ? 3 : k)), pin_c);
    end
    $display("serial test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 5'h00;
    wdata_i = 8'h00;
    ext_a = 8'h00;
    ext_b = 8'h00;
    ext_c = 8'h00;
    ser = 3'b111;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_irq;
    t_a;
    t_bc;
    t_serial;
    end_sim;
  end
  // Tests need about 110 cycles
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule // tvio_ports_tb_top
`default_nettype wire
